/* bench/host_model.sv */
// host processor model on the asynchronous strobe bus
// assumes the bench calls access from its own thread
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [4:0] addr,
  output logic [7:0] wdata
);
  ////////////////////////////////////////
  // idle bus: strobes high, address and data never idle at zero
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    {addr, wdata} = 13'h1555;
  end
  // one access held for a number of cycles, then released inverted
  task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
    input int hold);
    @(negedge clk);
    {cs_n, rd_n, wr_n, addr, wdata} = {1'b0, wr, !wr, a, d};
    repeat (hold) @(negedge clk);
    {cs_n, rd_n, wr_n, addr, wdata} = {3'h7, ~a, ~d};
  endtask
endmodule

/* bench/power_fail_lockout_control_checker.sv */
// checker for the power-fail lockout block, bound to its top module
// assumes one clock and the tick length handed on by the bind
`timescale 1ns/100ps
module power_fail_lockout_control_checker #(
  parameter int TICK_CYCLES = 4000
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SUPPLY_FAIL_N,
  input wire logic CS_N,
  input wire logic DATA_OE,
  input wire logic HOST_CS,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic [4:0] HOST_ADDR,
  input wire logic PF_INT_ENABLE,
  input wire logic DELAY_ENABLE_CLR,
  input wire logic DELAY_ENABLE,
  input wire logic PF_STATUS,
  input wire logic LOCKED_OUT,
  input wire logic STANDBY,
  input wire logic CLOCK_START,
  input wire logic OSC_FAIL,
  input wire logic BATTERY_LOW_DET,
  input wire logic LOW_BATTERY,
  input wire logic TIME_SAVE_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  int low_cnt_r;
  int high_cnt_r;
  ////////////////////////////////////////
  // run lengths of the raw supply pin, to bound both debounce edges
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      low_cnt_r <= 0;
      high_cnt_r <= 0;
    end else begin
      low_cnt_r <= SUPPLY_FAIL_N ? 0 : low_cnt_r + 1;
      high_cnt_r <= SUPPLY_FAIL_N ? high_cnt_r + 1 : 0;
    end
  end
  // steps of a lockout: window kept open, then lock soon after
  sequence win_open;
    !LOCKED_OUT [*8];
  endsequence
  sequence lock_soon;
    ##[0:3] LOCKED_OUT;
  endsequence
  lock_gate_a: assert property (LOCKED_OUT |-> !(HOST_CS || HOST_RD || HOST_WR)
    && HOST_ADDR == 5'h00) else $error("host access passed while locked");
  bus_free_a: assert property (LOCKED_OUT && $past(LOCKED_OUT) |-> !DATA_OE)
    else $error("data bus driven while locked");
  deb_min_a: assert property ($rose(PF_STATUS) |-> low_cnt_r >= TICK_CYCLES)
    else $error("power fail seen before debounce");
  deb_max_a: assert property (low_cnt_r == 2 * TICK_CYCLES + 6 |-> PF_STATUS)
    else $error("power fail late after debounce");
  prompt_a: assert property ($rose(PF_STATUS) && !DELAY_ENABLE && CS_N |->
    lock_soon) else $error("prompt lockout missing");
  window_a: assert property ($rose(PF_STATUS) && DELAY_ENABLE |-> win_open)
    else $error("delay window closed early");
  early_lock_a: assert property (DELAY_ENABLE_CLR && PF_STATUS |-> ##1 lock_soon)
    else $error("lockout not forced on delay clear");
  hold_lock_a: assert property (LOCKED_OUT && !SUPPLY_FAIL_N |=> LOCKED_OUT)
    else $error("unlocked while supply pin low");
  unlock_min_a: assert property ($fell(LOCKED_OUT) && !$past(STANDBY) |->
    high_cnt_r >= TICK_CYCLES) else $error("unlocked before debounce");
  osc_clear_a: assert property (CLOCK_START |-> ##[0:2] !OSC_FAIL)
    else $error("oscillator fail flag stuck");
  low_batt_a: assert property (LOW_BATTERY |-> $past(PF_INT_ENABLE) &&
    $past(BATTERY_LOW_DET)) else $error("low battery without cause");
  ts_clear_a: assert property ($rose(STANDBY) |-> ##[0:3] !TIME_SAVE_EN)
    else $error("time save kept in standby");
endmodule

/* bench/test_power_fail_lockout_control.sv */
// self-checking bench for the power-fail lockout block
// assumes a short tick so every interval fits a brief run
`timescale 1ns/100ps
module test_power_fail_lockout_control;
  localparam int TK = 8;
  logic clk, rstn, sf_n, above, bl_det, cs_n, rd_n, wr_n, pf_en, dl_set, dl_clr;
  logic t_in, i_in, cs_wr, cs_val, pfw, ts_set, ts_clr, doe, hcs, hrd, hwr, dl_en;
  logic t_run, i_run, pf_int, pf_st, locked, stby, odrain, cstart, bmode, oscf;
  logic lowb, ts_en;
  logic [4:0] addr, haddr;
  logic [7:0] din, dout, rdat, hwd, pfd;
  logic [47:0] cnt, tsd;
  logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b100, 3'b111};
  int failures, checks, cycles, n;
  power_fail_lockout_control #(.TICK_CYCLES(TK)) i_power_fail_lockout_control (
    .CLK(clk), .RSTN(rstn), .SUPPLY_FAIL_N(sf_n), .BATTERY_ABOVE_MAIN(above),
    .BATTERY_LOW_DET(bl_det), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .READ_DATA(rdat), .HOST_CS(hcs),
    .HOST_RD(hrd), .HOST_WR(hwr), .HOST_ADDR(haddr), .HOST_WDATA(hwd),
    .PF_INT_ENABLE(pf_en), .DELAY_ENABLE_SET(dl_set), .DELAY_ENABLE_CLR(dl_clr),
    .DELAY_ENABLE(dl_en), .TIMER_PF_RUN(t_in), .INT_PF_RUN(i_in), .TIMERS_RUN(t_run),
    .INTERRUPTS_RUN(i_run), .PF_INT(pf_int), .PF_STATUS(pf_st), .LOCKED_OUT(locked),
    .STANDBY(stby), .INT_OPEN_DRAIN(odrain), .CLOCK_START_WR(cs_wr),
    .CLOCK_START_VAL(cs_val), .CLOCK_START(cstart), .PERIODIC_FLAG_WR(pfw),
    .PERIODIC_FLAG_DATA(pfd), .BATTERY_MODE(bmode), .OSC_FAIL(oscf), .LOW_BATTERY(lowb),
    .TIME_SAVE_SET(ts_set), .TIME_SAVE_CLR(ts_clr), .TIME_SAVE_EN(ts_en),
    .CLOCK_COUNTERS(cnt), .TIME_SAVE_DATA(tsd));
  host_model i_host_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .wdata(din));
  ////////////////////////////////////////
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // bounded wait for the lockout level
  task automatic wait_lvl(input logic lv);
    for (n = 0; n < 300 && locked !== lv; n++) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {rstn, above, bl_det, rdat, pf_en, dl_set, dl_clr, cs_wr, cs_val, pfw} = '0;
    {pfd, ts_set, ts_clr, cnt} = '0;
    {sf_n, t_in, i_in} = 3'h7;
    cyc(6);
    rstn = 1'b1;
    cyc(4);
    chk({oscf, cstart, pf_st, locked}, 4'h8);
    for (int i = 0; i < 4; i++) begin
      {pf_en, bl_det} = rows[i][2:1];
      cyc(2);
      chk(lowb, rows[i][0]);
    end
    bl_det = 1'b0;
    rdat = 8'ha7;
    fork
      i_host_model.access(1'b1, 5'h0a, 8'h5c, 6);
      begin
        cyc(5);
        chk({hcs, hwr, haddr, hwd}, {2'b11, 5'h0a, 8'h5c});
      end
    join
    fork
      i_host_model.access(1'b0, 5'h01, 8'h00, 6);
      begin
        cyc(6);
        chk({hcs, hrd, doe, dout}, {3'b111, 8'ha7});
      end
    join
    pulse(pfw);
    cyc(1);
    chk({bmode, oscf}, 2'b11);
    cs_val = 1'b1;
    pulse(cs_wr);
    cyc(2);
    chk({cstart, oscf}, 2'b10);
    // prompt lockout with interrupt enabled
    t_in = 1'b0;
    sf_n = 1'b0;
    cyc(6);
    chk(pf_st, 1'b0);
    wait_lvl(1'b1);
    chk(n < 40, 1'b1);
    cyc(1);
    chk({pf_st, pf_int, t_run, i_run}, 4'b1101);
    fork
      i_host_model.access(1'b1, 5'h03, 8'h11, 4);
      begin
        cyc(4);
        chk({doe, hwr, haddr, hwd}, 0);
      end
    join
    sf_n = 1'b1;
    cyc(4);
    chk(locked, 1'b1);
    wait_lvl(1'b0);
    cyc(1);
    chk({n < 30, pf_st}, 2'b10);
    // masked interrupt still locks
    pf_en = 1'b0;
    sf_n = 1'b0;
    wait_lvl(1'b1);
    cyc(1);
    chk({pf_int, pf_st, locked}, 3'b011);
    sf_n = 1'b1;
    wait_lvl(1'b0);
    pf_en = 1'b1;
    // full delay window
    pulse(dl_set);
    chk(dl_en, 1'b1);
    sf_n = 1'b0;
    wait_lvl(1'b1);
    chk(n >= 120 && n <= 160, 1'b1);
    sf_n = 1'b1;
    wait_lvl(1'b0);
    // window cut short by clearing the delay bit
    pulse(dl_set);
    sf_n = 1'b0;
    for (n = 0; n < 40 && pf_st !== 1'b1; n++) cyc(1);
    cyc(20);
    chk(locked, 1'b0);
    pulse(dl_clr);
    cyc(3);
    chk({locked, dl_en}, 2'b10);
    sf_n = 1'b1;
    wait_lvl(1'b0);
    // strobe held across the failure: kept open at first, then forced shut
    fork
      i_host_model.access(1'b1, 5'h04, 8'h22, 80);
      begin
        sf_n = 1'b0;
        cyc(16);
        chk(locked, 1'b0);
        cyc(44);
        chk(locked, 1'b1);
      end
    join
    sf_n = 1'b1;
    wait_lvl(1'b0);
    // time save follows the counters until standby
    cnt = 48'h0123456789ab;
    pulse(ts_set);
    cyc(4);
    chk({ts_en, tsd}, {1'b1, 48'h0123456789ab});
    sf_n = 1'b0;
    wait_lvl(1'b1);
    cyc(2);
    chk(ts_en, 1'b1);
    above = 1'b1;
    cyc(4);
    chk({stby, odrain, ts_en, locked}, 4'b1101);
    cnt = 48'h000000000001;
    cyc(4);
    chk(tsd, 48'h0123456789ab);
    final_report();
  end
endmodule
bind power_fail_lockout_control power_fail_lockout_control_checker #(
  .TICK_CYCLES(TICK_CYCLES)) i_checker (.CLK(CLK), .RSTN(RSTN),
  .SUPPLY_FAIL_N(SUPPLY_FAIL_N), .CS_N(CS_N), .DATA_OE(DATA_OE), .HOST_CS(HOST_CS),
  .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR),
  .PF_INT_ENABLE(PF_INT_ENABLE), .DELAY_ENABLE_CLR(DELAY_ENABLE_CLR),
  .DELAY_ENABLE(DELAY_ENABLE), .PF_STATUS(PF_STATUS), .LOCKED_OUT(LOCKED_OUT),
  .STANDBY(STANDBY), .CLOCK_START(CLOCK_START), .OSC_FAIL(OSC_FAIL),
  .BATTERY_LOW_DET(BATTERY_LOW_DET), .LOW_BATTERY(LOW_BATTERY),
  .TIME_SAVE_EN(TIME_SAVE_EN));

/* src/power_fail_lockout_control.sv */
// power-fail supervision: debounce, interrupt, bus lock-out, status bits
// assumes async pins synchronised here; ticks from the internal timebase
`timescale 1ns/100ps
`include "supply_fail_n_defines.svh"
module power_fail_lockout_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DEBOUNCE_TICKS = `DEBOUNCE_TICKS,
  parameter int DELAY_WINDOW_TICKS = `DELAY_WINDOW_TICKS,
  parameter int STROBE_LIMIT_TICKS = `STROBE_LIMIT_TICKS,
  parameter int TIME_WIDTH = `TIME_WIDTH
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SUPPLY_FAIL_N,
  input wire logic BATTERY_ABOVE_MAIN,
  input wire logic BATTERY_LOW_DET,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic [7:0] READ_DATA,
  output logic HOST_CS,
  output logic HOST_RD,
  output logic HOST_WR,
  output logic [4:0] HOST_ADDR,
  output logic [7:0] HOST_WDATA,
  input wire logic PF_INT_ENABLE,
  input wire logic DELAY_ENABLE_SET,
  input wire logic DELAY_ENABLE_CLR,
  output logic DELAY_ENABLE,
  input wire logic TIMER_PF_RUN,
  input wire logic INT_PF_RUN,
  output logic TIMERS_RUN,
  output logic INTERRUPTS_RUN,
  output logic PF_INT,
  output logic PF_STATUS,
  output logic LOCKED_OUT,
  output logic STANDBY,
  output logic INT_OPEN_DRAIN,
  input wire logic CLOCK_START_WR,
  input wire logic CLOCK_START_VAL,
  output logic CLOCK_START,
  input wire logic PERIODIC_FLAG_WR,
  input wire logic [7:0] PERIODIC_FLAG_DATA,
  output logic BATTERY_MODE,
  output logic OSC_FAIL,
  output logic LOW_BATTERY,
  input wire logic TIME_SAVE_SET,
  input wire logic TIME_SAVE_CLR,
  output logic TIME_SAVE_EN,
  input wire logic [TIME_WIDTH-1:0] CLOCK_COUNTERS,
  output logic [TIME_WIDTH-1:0] TIME_SAVE_DATA
);
  import supply_fail_n_pkg::*;

  tick_if tk ();

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the async pins; stage one read only by stage two
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_r <= 5'h1f;
      sync2_r <= 5'h1f;
    end else begin
      sync1_r <= {SUPPLY_FAIL_N, BATTERY_ABOVE_MAIN, CS_N, RD_N, WR_N};
      sync2_r <= sync1_r;
    end
  end
  logic supply_fail_n_n_s;
  logic standby_s;
  logic cs_s;
  logic strobe_s;
  assign supply_fail_n_n_s = sync2_r[4];
  assign standby_s = sync2_r[3];
  assign cs_s = !sync2_r[2];
  assign strobe_s = !sync2_r[1] || !sync2_r[0];

  ref_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .CLK(CLK),
    .RSTN(RSTN),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////
  // debounce: the pin level must hold across whole ticks before it counts
  logic pfailed_r;
  logic pfailed_nxt;
  logic [3:0] deb_r;
  logic [3:0] deb_nxt;
  always_comb begin
    pfailed_nxt = pfailed_r;
    deb_nxt = deb_r;
    if (supply_fail_n_n_s == !pfailed_r) begin
      deb_nxt = 4'h0; // level agrees with state, restart
    end else if (tk.tick) begin
      if (deb_r == 4'(DEBOUNCE_TICKS)) begin
        pfailed_nxt = !supply_fail_n_n_s;
        deb_nxt = 4'h0;
      end else begin
        deb_nxt = deb_r + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pfailed_r <= 1'b0;
      deb_r <= 4'h0;
    end else begin
      pfailed_r <= pfailed_nxt;
      deb_r <= deb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock-out sequencer; delay bit sampled live so a clear ends the window
  lock_state_type state_r;
  lock_state_type state_nxt;
  logic [4:0] win_r;
  logic [4:0] win_nxt;
  logic [3:0] stb_r;
  logic [3:0] stb_nxt;
  logic delay_en_r;
  logic delay_en_nxt;
  logic in_access;
  assign in_access = cs_s && strobe_s;

  always_comb begin
    state_nxt = state_r;
    win_nxt = win_r;
    stb_nxt = stb_r;
    case (state_r)
      ST_POWER_OK: begin
        // counters rest only while power is good; the strobe count spans up to two ticks
        if (!pfailed_r) begin
          win_nxt = 5'h00;
          stb_nxt = 4'h0;
        end else begin
          // hold off while a cycle is in flight
          if (delay_en_r) begin
            state_nxt = ST_WINDOW;
          end else if (!in_access) begin
            state_nxt = ST_LOCKED;
          end else if (tk.tick) begin
            if (stb_r == 4'(STROBE_LIMIT_TICKS)) begin
              state_nxt = ST_LOCKED;
            end else begin
              stb_nxt = stb_r + 4'h1;
            end
          end
        end
      end
      ST_WINDOW: begin
        if (!delay_en_r && !in_access) begin
          state_nxt = ST_LOCKED;
        end else if (tk.tick) begin
          if (win_r == 5'(DELAY_WINDOW_TICKS - 1)) begin
            state_nxt = ST_LOCKED;
          end else begin
            win_nxt = win_r + 5'h01;
          end
        end
        if (!pfailed_r) begin
          state_nxt = ST_POWER_OK; // failure debounced away
        end
      end
      ST_LOCKED: begin
        if (!pfailed_r) begin
          state_nxt = ST_POWER_OK;
        end
      end
      default: begin
        state_nxt = ST_POWER_OK;
      end
    endcase
  end

  // delay enable: host sets or clears; set wins when both arrive together
  always_comb begin
    delay_en_nxt = delay_en_r;
    if (DELAY_ENABLE_SET) begin
      delay_en_nxt = 1'b1;
    end else if (DELAY_ENABLE_CLR) begin
      delay_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_POWER_OK;
      win_r <= 5'h00;
      stb_r <= 4'h0;
      delay_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      win_r <= win_nxt;
      stb_r <= stb_nxt;
      delay_en_r <= delay_en_nxt;
    end
  end

  logic locked;
  assign locked = (state_r == ST_LOCKED) || standby_s;

  ////////////////////////////////////////////////////////////////////////
  // host bus isolation: inputs masked, data bus released
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic doe_r;
  logic doe_nxt;
  always_comb begin
    doe_nxt = !locked && cs_s && !sync2_r[1];
    dout_nxt = doe_nxt ? READ_DATA : 8'h00;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dout_r <= 8'h00;
      doe_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
    end
  end

  assign DATA_OUT = dout_r;
  assign DATA_OE = doe_r;
  assign HOST_CS = cs_s && !locked;
  assign HOST_RD = HOST_CS && !sync2_r[1];
  assign HOST_WR = HOST_CS && !sync2_r[0];
  assign HOST_ADDR = locked ? 5'h00 : ADDR;
  assign HOST_WDATA = locked ? 8'h00 : DATA_IN;

  ////////////////////////////////////////////////////////////////////////
  // status and mode bits
  logic osc_fail_r;
  logic osc_fail_nxt;
  logic clk_start_r;
  logic clk_start_nxt;
  logic batt_mode_r;
  logic batt_mode_nxt;
  logic low_batt_r;
  logic low_batt_nxt;
  logic ts_en_r;
  logic ts_en_nxt;
  logic standby_d_r;
  logic standby_d_nxt;
  always_comb begin
    clk_start_nxt = CLOCK_START_WR ? CLOCK_START_VAL : clk_start_r;
    // flag survives until the clock is running
    osc_fail_nxt = clk_start_r ? 1'b0 : osc_fail_r;
    batt_mode_nxt = batt_mode_r;
    if (PERIODIC_FLAG_WR) begin
      batt_mode_nxt = !PERIODIC_FLAG_DATA[`BATT_MODE_BIT];
    end
    // detector only live on main supply with enable
    low_batt_nxt = BATTERY_LOW_DET && !standby_s && PF_INT_ENABLE;
    standby_d_nxt = standby_s;
    ts_en_nxt = ts_en_r;
    if (TIME_SAVE_CLR) begin
      ts_en_nxt = 1'b0;
    end
    if (TIME_SAVE_SET) begin
      ts_en_nxt = 1'b1;
    end
    // battery switch-in freezes the snapshot; the pin alone does not
    if (standby_s && !standby_d_r) begin
      ts_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_fail_r <= `OSC_FAIL_RST;
      clk_start_r <= `CLK_START_RST;
      batt_mode_r <= 1'b0;
      low_batt_r <= 1'b0;
      ts_en_r <= 1'b0;
      standby_d_r <= 1'b1; // matches the comparator preload, no false edge
    end else begin
      osc_fail_r <= osc_fail_nxt;
      clk_start_r <= clk_start_nxt;
      batt_mode_r <= batt_mode_nxt;
      low_batt_r <= low_batt_nxt;
      ts_en_r <= ts_en_nxt;
      standby_d_r <= standby_d_nxt;
    end
  end

  time_save_ram #(.WIDTH(TIME_WIDTH)) u_ts (
    .CLK(CLK),
    .RSTN(RSTN),
    .load(ts_en_r),
    .wdata(CLOCK_COUNTERS),
    .rdata(TIME_SAVE_DATA)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs; interrupt masked by enable but lock-out unaffected
  assign PF_STATUS = pfailed_r;
  assign PF_INT = pfailed_r && PF_INT_ENABLE;
  assign LOCKED_OUT = locked;
  assign STANDBY = standby_s;
  assign INT_OPEN_DRAIN = standby_s;
  assign TIMERS_RUN = !pfailed_r || TIMER_PF_RUN;
  assign INTERRUPTS_RUN = !pfailed_r || INT_PF_RUN;
  assign DELAY_ENABLE = delay_en_r;
  assign CLOCK_START = clk_start_r;
  assign BATTERY_MODE = batt_mode_r;
  assign OSC_FAIL = osc_fail_r;
  assign LOW_BATTERY = low_batt_r;
  assign TIME_SAVE_EN = ts_en_r;
endmodule

/* src/ref_tick_gen.sv */
// fixed reference tick generator, one pulse per tick period
// assumes CLK is the only clock
`timescale 1ns/100ps
`include "supply_fail_n_defines.svh"
module ref_tick_gen #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  tick_if.source tk
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  ////////////////////////////////////////////////////////////////////////
  // wrap counter; a free-running tick makes debounce land in 32-64 us
  always_comb begin
    tick_nxt = 1'b0;
    if (cnt_r == 16'(TICK_CYCLES - 1)) begin
      cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick = tick_r;
endmodule

/* src/supply_fail_n_defines.svh */
// timing constants and reset values for the power-fail lockout block
// assumes a 125 MHz system clock; included by bare name
`ifndef SUPPLY_FAIL_N_DEFINES_SVH
`define SUPPLY_FAIL_N_DEFINES_SVH

`define CLK_FREQ_MHZ 125
`define TICK_US 32
`define TICK_CYCLES (`TICK_US * `CLK_FREQ_MHZ)
`define DEBOUNCE_US 32
`define DEBOUNCE_TICKS (`DEBOUNCE_US / `TICK_US)
`define DELAY_WINDOW_US 480
`define DELAY_WINDOW_TICKS (`DELAY_WINDOW_US / `TICK_US)
`define STROBE_LIMIT_US 32
`define STROBE_LIMIT_TICKS (`STROBE_LIMIT_US / `TICK_US)
`define TIME_WIDTH 48
`define BATT_MODE_BIT 6
`define OSC_FAIL_RST 1'b1
`define CLK_START_RST 1'b0

`endif

/* src/supply_fail_n_pkg.sv */
// types shared by the power-fail lockout block
// assumes the defines header for widths
package supply_fail_n_pkg;
  typedef enum {ST_POWER_OK, ST_WINDOW, ST_LOCKED, ST_RECOVER} lock_state_type;
endpackage

/* src/tick_if.sv */
// carrier of the reference tick between the timebase and the top
// assumes a single clock domain
`timescale 1ns/100ps
interface tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface

/* src/time_save_ram.sv */
// time-save storage: holds a snapshot of the clock counters
// assumes load is a same-clock strobe; read data registered
`timescale 1ns/100ps
`include "supply_fail_n_defines.svh"
module time_save_ram #(
  parameter int WIDTH = `TIME_WIDTH
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic load,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_r;
  logic [WIDTH-1:0] mem_nxt;

  ////////////////////////////////////////////////////////////////////////
  // follow the counters while loading, otherwise freeze
  always_comb begin
    mem_nxt = load ? wdata : mem_r;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign rdata = mem_r;
endmodule
